/* File: verilog/sbl_loader.sv */
// serial boot loader: mode latch, rate alignment, download, hand-off
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
module sbl_loader #(
  parameter int CNT_W = 21,
  parameter int DIV_W = 17,
  parameter int unsigned CLK_HZ = sbl_pkg::CLOCK_HZ
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_hard_init_pin_n,
  input wire logic i_mode_strap_high_hv,
  input wire logic i_mode_strap_high,
  input wire logic i_mode_strap_low,
  input wire logic i_flash_hv_pin,
  input wire logic i_boot_rx_pin,
  input wire logic i_standby_req,
  input wire logic i_wdt_reset,
  input wire logic i_flash_blank,
  input wire logic i_erase_done,
  input wire logic i_flash_busy,
  input wire logic i_flash_access,
  input wire logic [1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  output logic [31:0] o_reg_rdata,
  output logic o_boot_tx_pin,
  output logic o_tx_pin_dir_bit,
  output logic o_tx_pin_out_bit,
  output logic o_rx_on_bit,
  output logic o_tx_on_bit,
  output logic [DIV_W-1:0] o_baud_divisor,
  output logic o_ram_we,
  output logic [15:0] o_ram_addr,
  output logic [7:0] o_ram_wdata,
  output logic o_jump,
  output logic [15:0] o_jump_addr,
  output logic o_erase_all,
  output logic o_irq_block,
  output logic o_flash_read_block,
  output logic o_reserved_lock,
  output logic o_boot_mode,
  output logic o_mode3,
  output logic o_user_prog_mode,
  output logic o_standby_grant
);
  import sbl_pkg::*;

  // clocks per bit follow the clock actually fitted
  localparam int unsigned CPB_F = CLK_HZ / BPS_FAST;
  localparam int unsigned CPB_M = CLK_HZ / BPS_MID;
  localparam int unsigned CPB_S = CLK_HZ / BPS_SLOW;

  if (DIV_W > CNT_W || (64'd1 << DIV_W) <= 64'(CPB_S) || (64'd1 << CNT_W) <= 64'(CPB_S * LOW_BITS) ||
      (CPB_F >> CPB_TOL_SHIFT) == 0)
  begin : g_check
    $error("sbl_loader: counter widths cannot hold the slowest rate");
  end

  localparam logic [CNT_W-1:0] NINE = CNT_W'(LOW_BITS);
  localparam logic [9:0] READY_LAST = 10'(READY_CYC - 1);

  // every pin input passes two flops; index order below
  logic [PIN_COUNT-1:0] pin_raw, pin_m, pin_s;
  assign pin_raw = {i_standby_req, i_boot_rx_pin, i_flash_hv_pin, i_mode_strap_low,
                    i_mode_strap_high, i_mode_strap_high_hv, i_hard_init_pin_n};
  for (genvar g = 0; g < PIN_COUNT; g++)
  begin : g_sync
    always_ff @(posedge i_clock)
    begin
      pin_m[g] <= i_srst ? 1'b1 : pin_raw[g];
      pin_s[g] <= i_srst ? 1'b1 : pin_m[g];
    end
  end
  logic hard_s, md1_hv_s, md1_s, md0_s, flash_hv_pin_s, rx_s, stby_s;
  assign {stby_s, rx_s, flash_hv_pin_s, md0_s, md1_s, md1_hv_s, hard_s} = pin_s;

  logic hard_p, rx_p;
  always_ff @(posedge i_clock)
  begin
    hard_p <= i_srst ? 1'b1 : hard_s;
    rx_p <= i_srst ? 1'b1 : rx_s;
  end
  wire hard_rise = hard_s & ~hard_p;

  // boot latch: only the external init pin or i_srst clears it, not the watchdog
  logic boot_q, mode3_q, rom_q;
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      boot_q <= 1'b0;
      mode3_q <= 1'b0;
      rom_q <= 1'b0;
    end
    else if (hard_rise) // latch moves only on a pin release
    begin
      boot_q <= md1_hv_s & flash_hv_pin_s;
      mode3_q <= md0_s;
      rom_q <= md1_s | md1_hv_s;
    end
  end

  sbl_state_t st_q;
  logic [9:0] rdy_q;
  logic [CNT_W-1:0] cnt_q, quot_q;
  logic [DIV_W-1:0] div_q;
  logic rx_on_q, tx_on_q, tx_go_q, jumped_q, fail_q, align_q;
  logic [7:0] tx_byte_q;
  logic [15:0] len_q, addr_q;
  logic rx_done_q, tx_busy_q, tx_done;
  logic [7:0] rx_byte_q;

  function automatic logic in_band(input logic [CNT_W-1:0] q, input int unsigned c);
    int unsigned v;
    v = int'(q);
    return (v >= c - (c >> CPB_TOL_SHIFT)) && (v <= c + (c >> CPB_TOL_SHIFT));
  endfunction
  // outside the three bands the rate cannot be served; no answer is sent
  wire rate_ok = in_band(quot_q, CPB_F) | in_band(quot_q, CPB_M) | in_band(quot_q, CPB_S);
  wire [15:0] len_clamp = (len_q > USER_RAM_BYTES) ? USER_RAM_BYTES : len_q;

  // loader sequence
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      st_q <= S_HOLD;
      rdy_q <= 10'h000;
      cnt_q <= '0;
      quot_q <= '0;
      tx_go_q <= 1'b0;
      tx_byte_q <= 8'h00;
      len_q <= 16'h0000;
      addr_q <= USER_RAM_FIRST;
      jumped_q <= 1'b0;
      fail_q <= 1'b0;
      align_q <= 1'b0;
    end
    else if (!hard_s || (i_wdt_reset && boot_q))
    begin
      st_q <= S_HOLD;
      rdy_q <= 10'h000;
      tx_go_q <= 1'b0;
      jumped_q <= 1'b0;
      fail_q <= 1'b0;
      align_q <= 1'b0;
    end
    else
    begin
      tx_go_q <= 1'b0;
      case (st_q)
        S_HOLD:
          if (!hard_rise)
          begin
            st_q <= boot_q ? S_READY : S_RUN;
          end
        S_READY:
          if (rdy_q == READY_LAST)
          begin
            st_q <= S_WAIT_HIGH;
          end
          else
          begin
            rdy_q <= rdy_q + 10'h001;
          end
        S_WAIT_HIGH:
          if (rx_s)
          begin
            st_q <= S_WAIT_LOW;
          end
        S_WAIT_LOW:
          if (!rx_s)
          begin
            cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1};
            st_q <= S_MEASURE;
          end
        S_MEASURE:
          if (rx_s) // start bit plus eight zero data bits end here
          begin
            quot_q <= '0;
            st_q <= S_DIVIDE;
          end
          else if (&cnt_q)
          begin
            st_q <= S_FAIL;
          end
          else
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        S_DIVIDE:
          if (cnt_q >= NINE) // repeated subtraction, cheap and not time critical
          begin
            cnt_q <= cnt_q - NINE;
            quot_q <= quot_q + 1'b1;
          end
          else
          begin
            st_q <= S_CHECK;
          end
        S_CHECK:
          if (rate_ok)
          begin
            align_q <= 1'b1;
            tx_byte_q <= ALIGN_DONE_BYTE;
            tx_go_q <= 1'b1;
            st_q <= S_SEND;
          end
          else
          begin
            st_q <= S_FAIL;
          end
        S_SEND:
          if (tx_done)
          begin
            st_q <= S_WAIT_ACK;
          end
        S_WAIT_ACK:
          if (rx_done_q && rx_byte_q == HOST_ACK_BYTE)
          begin
            st_q <= S_ERASE;
          end
        S_ERASE:
          if (i_flash_blank || i_erase_done)
          begin
            st_q <= S_LEN_HI;
          end
        S_LEN_HI:
          if (rx_done_q)
          begin
            len_q[15:8] <= rx_byte_q;
            st_q <= S_LEN_LO;
          end
        S_LEN_LO:
          if (rx_done_q)
          begin
            len_q[7:0] <= rx_byte_q;
            addr_q <= USER_RAM_FIRST;
            st_q <= S_LOAD;
          end
        S_LOAD:
          if (len_clamp == 16'h0000)
          begin
            st_q <= S_HANDOFF;
          end
          else if (rx_done_q)
          begin
            addr_q <= addr_q + 16'h0001;
            len_q <= len_clamp - 16'h0001;
          end
        S_HANDOFF:
          begin
            jumped_q <= 1'b1;
            st_q <= S_RUN;
          end
        S_RUN:
          st_q <= S_RUN;
        S_FAIL:
          fail_q <= 1'b1;
        default:
          st_q <= S_HOLD;
      endcase
    end
  end

  // serial enables and divisor; loader writes win over software
  wire sw_ctrl = i_reg_we && i_reg_addr == REG_CTRL;
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      rx_on_q <= 1'b0;
      tx_on_q <= 1'b0;
      div_q <= '0;
      o_tx_pin_dir_bit <= 1'b0;
      o_tx_pin_out_bit <= 1'b0;
    end
    else if (st_q == S_HOLD)
    begin
      rx_on_q <= 1'b0;
      tx_on_q <= 1'b0;
    end
    else if (st_q == S_CHECK && rate_ok)
    begin
      div_q <= DIV_W'(quot_q - 1'b1); // clocks per bit minus one
      rx_on_q <= 1'b1;
      tx_on_q <= 1'b1;
    end
    else if (st_q == S_HANDOFF)
    begin
      rx_on_q <= 1'b0; // divisor deliberately left as aligned
      tx_on_q <= 1'b0;
      o_tx_pin_dir_bit <= 1'b1;
      o_tx_pin_out_bit <= 1'b1;
    end
    else if (i_reg_we && i_reg_addr == REG_BAUD)
    begin
      div_q <= i_reg_wdata[DIV_W-1:0];
    end
    else if (sw_ctrl)
    begin
      rx_on_q <= i_reg_wdata[CTRL_RX_POS];
      tx_on_q <= i_reg_wdata[CTRL_TX_POS];
    end
  end

  // receiver, 8N1, sampled mid-bit
  logic rx_busy_q;
  logic [DIV_W-1:0] rx_tmr_q;
  logic [3:0] rx_n_q;
  always_ff @(posedge i_clock)
  begin
    if (i_srst || !rx_on_q)
    begin
      rx_busy_q <= 1'b0;
      rx_tmr_q <= '0;
      rx_n_q <= 4'h0;
      rx_done_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end
    else
    begin
      rx_done_q <= 1'b0;
      if (!rx_busy_q)
      begin
        if (rx_p && !rx_s)
        begin
          rx_busy_q <= 1'b1;
          rx_tmr_q <= div_q >> 1;
          rx_n_q <= 4'h0;
        end
      end
      else if (rx_tmr_q != '0)
      begin
        rx_tmr_q <= rx_tmr_q - 1'b1;
      end
      else if (rx_n_q == 4'h0 && rx_s)
      begin
        rx_busy_q <= 1'b0; // glitch, not a start bit
      end
      else if (rx_n_q == 4'h9)
      begin
        rx_busy_q <= 1'b0;
        rx_done_q <= rx_s; // framing error drops the byte
      end
      else
      begin
        if (rx_n_q != 4'h0)
        begin
          rx_byte_q <= {rx_s, rx_byte_q[7:1]};
        end
        rx_n_q <= rx_n_q + 4'h1;
        rx_tmr_q <= div_q;
      end
    end
  end

  // transmitter, 8N1, line idles high
  logic [DIV_W-1:0] tx_tmr_q;
  logic [3:0] tx_n_q;
  logic [8:0] tx_sh_q;
  assign tx_done = tx_busy_q && tx_tmr_q == '0 && tx_n_q == 4'h9;
  always_ff @(posedge i_clock)
  begin
    if (i_srst || !tx_on_q)
    begin
      tx_busy_q <= 1'b0;
      tx_tmr_q <= '0;
      tx_n_q <= 4'h0;
      tx_sh_q <= 9'h1ff;
      o_boot_tx_pin <= 1'b1;
    end
    else if (tx_go_q && !tx_busy_q)
    begin
      tx_busy_q <= 1'b1;
      tx_sh_q <= {1'b1, tx_byte_q};
      o_boot_tx_pin <= 1'b0;
      tx_tmr_q <= div_q;
      tx_n_q <= 4'h0;
    end
    else if (tx_busy_q)
    begin
      if (tx_tmr_q != '0)
      begin
        tx_tmr_q <= tx_tmr_q - 1'b1;
      end
      else if (tx_n_q == 4'h9)
      begin
        tx_busy_q <= 1'b0;
      end
      else
      begin
        o_boot_tx_pin <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[8:1]};
        tx_n_q <= tx_n_q + 4'h1;
        tx_tmr_q <= div_q;
      end
    end
  end

  // flash, RAM and mode side effects
  logic upm_q;
  wire erasing = st_q == S_ERASE && !i_flash_blank;
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_ram_we <= 1'b0;
      o_ram_addr <= USER_RAM_FIRST;
      o_ram_wdata <= 8'h00;
      o_jump <= 1'b0;
      o_jump_addr <= 16'h0000;
      o_erase_all <= 1'b0;
      o_irq_block <= 1'b0;
      o_flash_read_block <= 1'b0;
      o_reserved_lock <= 1'b0;
      o_standby_grant <= 1'b0;
      upm_q <= 1'b0;
    end
    else
    begin
      o_ram_we <= st_q == S_LOAD && rx_done_q && len_clamp != 16'h0000 && addr_q <= USER_RAM_LAST;
      o_ram_addr <= addr_q;
      o_ram_wdata <= rx_byte_q;
      o_jump <= st_q == S_HANDOFF && hard_s;
      o_jump_addr <= (st_q == S_HANDOFF) ? JUMP_ADDR : o_jump_addr;
      o_erase_all <= erasing && hard_s;
      o_irq_block <= (erasing && hard_s) || i_flash_busy;
      o_flash_read_block <= (erasing && hard_s) || i_flash_busy;
      o_reserved_lock <= boot_q && !jumped_q && st_q != S_HANDOFF;
      o_standby_grant <= stby_s && !flash_hv_pin_s;
      // user mode may start during reset or when flash is idle
      if (!flash_hv_pin_s || boot_q)
      begin
        upm_q <= 1'b0;
      end
      // high strap at 12 V asks for boot, not user mode
      else if ((!hard_s && md1_s && !md1_hv_s) || (hard_s && rom_q && !i_flash_access))
      begin
        upm_q <= 1'b1;
      end
    end
  end

  // status and control words built bit by bit, no shifts of single bits
  logic [31:0] status_w, ctrl_w;
  always_comb
  begin
    status_w = 32'h0000_0000;
    status_w[ST_BOOT_POS] = boot_q;
    status_w[ST_MODE3_POS] = mode3_q;
    status_w[ST_UPM_POS] = upm_q;
    status_w[ST_JUMP_POS] = jumped_q;
    status_w[ST_FAIL_POS] = fail_q;
    status_w[ST_ALIGN_POS] = align_q;
    ctrl_w = 32'h0000_0000;
    ctrl_w[CTRL_RX_POS] = rx_on_q;
    ctrl_w[CTRL_TX_POS] = tx_on_q;
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge i_clock)
  begin
    if (i_srst || !i_reg_re)
    begin
      o_reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      case (i_reg_addr)
        REG_STATUS:
          o_reg_rdata <= status_w;
        REG_BAUD:
          o_reg_rdata <= 32'(div_q);
        REG_CTRL:
          o_reg_rdata <= ctrl_w;
        default:
          o_reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  assign o_rx_on_bit = rx_on_q;
  assign o_tx_on_bit = tx_on_q;
  assign o_baud_divisor = div_q;
  assign o_boot_mode = boot_q;
  assign o_mode3 = mode3_q;
  assign o_user_prog_mode = upm_q;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_aligned; st_q == S_CHECK && rate_ok; endsequence
  sequence s_ready_done; st_q == S_READY ##1 st_q == S_WAIT_HIGH; endsequence
  ram_window_a: assert property (o_ram_we |-> o_ram_addr >= USER_RAM_FIRST && o_ram_addr <= USER_RAM_LAST)
    else $error("ram write outside user window");
  ldr_area_a: assert property (o_ram_we |-> !(o_ram_addr <= LDR_RAM_A_LAST) && !(o_ram_addr >= LDR_RAM_B_FIRST))
    else $error("ram write into loader area");
  jump_target_a: assert property (o_jump |-> o_jump_addr == JUMP_ADDR && !o_reserved_lock)
    else $error("jump not to window base");
  handoff_pins_a: assert property (o_jump |-> !o_rx_on_bit && !o_tx_on_bit && o_tx_pin_dir_bit && o_tx_pin_out_bit
    && $stable(o_baud_divisor))
    else $error("serial state wrong at jump");
  erase_irq_a: assert property (o_erase_all |-> o_irq_block && o_flash_read_block)
    else $error("interrupts open during erase");
  standby_hv_a: assert property (flash_hv_pin_s |=> !o_standby_grant)
    else $error("standby granted under high voltage");
  boot_hold_a: assert property (!hard_rise |=> $stable(boot_q))
    else $error("boot latch changed without pin release");
  ready_delay_a: assert property (s_ready_done |-> $past(rdy_q, 1) == READY_LAST)
    else $error("loader ready at wrong time");
  align_byte_a: assert property (s_aligned |=> st_q == S_SEND && tx_go_q && tx_byte_q == ALIGN_DONE_BYTE
    ##1 !o_boot_tx_pin)
    else $error("alignment byte not started");
  divisor_load_a: assert property (s_aligned |=> o_baud_divisor == DIV_W'($past(quot_q) - 1'b1))
    else $error("divisor not clocks per bit minus one");
endmodule

/* File: common/sbl_pkg.sv */
// constants, register map and state encoding of the serial boot loader
package sbl_pkg;
  localparam int unsigned CLOCK_HZ = 200_000_000;
  localparam int unsigned READY_STATES = 100;
  localparam int unsigned READY_CYC = READY_STATES;
  localparam int unsigned LOW_BITS = 9;
  localparam int unsigned BPS_FAST = 9600;
  localparam int unsigned BPS_MID = 4800;
  localparam int unsigned BPS_SLOW = 2400;
  localparam int unsigned CPB_FAST = CLOCK_HZ / BPS_FAST;
  localparam int unsigned CPB_MID = CLOCK_HZ / BPS_MID;
  localparam int unsigned CPB_SLOW = CLOCK_HZ / BPS_SLOW;
  localparam int unsigned CPB_TOL_SHIFT = 5;
  localparam logic [7:0] ALIGN_DONE_BYTE = 8'h00;
  localparam logic [7:0] HOST_ACK_BYTE = 8'h55;
  localparam logic [15:0] USER_RAM_FIRST = 16'hfbe0;
  localparam logic [15:0] USER_RAM_LAST = 16'hff6d;
  localparam logic [15:0] USER_RAM_BYTES = 16'h038e;
  localparam logic [15:0] LDR_RAM_A_FIRST = 16'hfb80;
  localparam logic [15:0] LDR_RAM_A_LAST = 16'hfbdf;
  localparam logic [15:0] LDR_RAM_B_FIRST = 16'hff6e;
  localparam logic [15:0] LDR_RAM_B_LAST = 16'hff7f;
  localparam logic [15:0] JUMP_ADDR = USER_RAM_FIRST;
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_BAUD = 2'h1;
  localparam logic [1:0] REG_CTRL = 2'h2;
  localparam int unsigned CTRL_RX_POS = 0;
  localparam int unsigned CTRL_TX_POS = 1;
  localparam int unsigned ST_BOOT_POS = 0;
  localparam int unsigned ST_MODE3_POS = 1;
  localparam int unsigned ST_UPM_POS = 2;
  localparam int unsigned ST_JUMP_POS = 3;
  localparam int unsigned ST_FAIL_POS = 4;
  localparam int unsigned ST_ALIGN_POS = 5;
  localparam int unsigned PIN_COUNT = 7;
  typedef enum logic [3:0] {
    S_HOLD = 4'h0, S_READY = 4'h1, S_WAIT_HIGH = 4'h2, S_WAIT_LOW = 4'h3,
    S_MEASURE = 4'h4, S_DIVIDE = 4'h5, S_CHECK = 4'h6, S_SEND = 4'h7,
    S_WAIT_ACK = 4'h8, S_ERASE = 4'h9, S_LEN_HI = 4'ha, S_LEN_LO = 4'hb,
    S_LOAD = 4'hc, S_HANDOFF = 4'hd, S_RUN = 4'he, S_FAIL = 4'hf
  } sbl_state_t;
endpackage

/* File: tb/sbl_host_model.sv */
// host side of the boot serial link: 8n1 sender and receiver
`timescale 1ns/1ps
module sbl_host_model #(
  parameter int CPB = 20833
) (
  input wire logic i_clock,
  input wire logic i_tx_line,
  output logic o_rx_line,
  output logic [7:0] o_rx_byte,
  output logic o_rx_stop,
  output logic [7:0] o_rx_count
);
  initial
  begin
    o_rx_line = 1'b1;
    o_rx_byte = 8'h00;
    o_rx_stop = 1'b0;
    o_rx_count = 8'h00;
  end

  // start bit, data lsb first, one stop bit, no parity; line idles high
  task automatic send_byte(input logic [7:0] b, input int cpb);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      o_rx_line <= f[i];
      repeat (cpb) @(posedge i_clock);
    end
  endtask

  // mid-bit sampling at the nominal rate; a loose device rate shows as a wrong byte
  always
  begin
    @(negedge i_tx_line);
    repeat (CPB / 2) @(posedge i_clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (CPB) @(posedge i_clock);
      o_rx_byte[i] = i_tx_line;
    end
    repeat (CPB) @(posedge i_clock);
    o_rx_stop = i_tx_line;
    o_rx_count = o_rx_count + 8'h01;
  end
endmodule

/* File: tb/sbl_loader_tb.sv */
// self-checking bench for the serial boot loader
`timescale 1ns/1ps
module sbl_loader_tb;
  import sbl_pkg::*;
  // slow model clock keeps a byte at a few thousand cycles
  localparam int SIM_HZ = 4_800_000;
  localparam int CPB = SIM_HZ / BPS_FAST;
  localparam int LIMIT = 70_000;
  logic clk = 1'b0, srst = 1'b1, init_n = 1'b0, hv_md = 1'b1, md_high = 1'b1, md_low = 1'b1;
  logic flash_hv_pin = 1'b1, standby = 1'b0, wdt = 1'b0, blank = 1'b0, erase_done = 1'b0, busy = 1'b0;
  logic access = 1'b0, we = 1'b0, re = 1'b0, jump_seen = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic tx, dir, outb, rx_on, tx_on, ram_we, jump, erase_all, irq_blk, frb, lock, boot, mode3, upm, grant;
  logic [16:0] div;
  logic [15:0] ram_addr, jump_addr, jaddr;
  logic [7:0] ram_wdata, rx_byte, rx_cnt;
  logic rx_line, rx_stop;
  logic [15:0] wa [$];
  logic [7:0] wd [$];
  logic [7:0] seq [4] = '{8'h00, 8'h02, 8'ha5, 8'h3c};
  int total_checks = 0;
  int err_total = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  sbl_loader #(.CLK_HZ(SIM_HZ)) sbl_loader_inst (
    .i_clock(clk), .i_srst(srst), .i_hard_init_pin_n(init_n),
    .i_mode_strap_high_hv(hv_md), .i_mode_strap_high(md_high), .i_mode_strap_low(md_low),
    .i_flash_hv_pin(flash_hv_pin), .i_boot_rx_pin(rx_line), .i_standby_req(standby), .i_wdt_reset(wdt),
    .i_flash_blank(blank), .i_erase_done(erase_done), .i_flash_busy(busy), .i_flash_access(access),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rdata),
    .o_boot_tx_pin(tx), .o_tx_pin_dir_bit(dir), .o_tx_pin_out_bit(outb), .o_rx_on_bit(rx_on),
    .o_tx_on_bit(tx_on), .o_baud_divisor(div), .o_ram_we(ram_we), .o_ram_addr(ram_addr),
    .o_ram_wdata(ram_wdata), .o_jump(jump), .o_jump_addr(jump_addr), .o_erase_all(erase_all),
    .o_irq_block(irq_blk), .o_flash_read_block(frb), .o_reserved_lock(lock), .o_boot_mode(boot),
    .o_mode3(mode3), .o_user_prog_mode(upm), .o_standby_grant(grant)
  );

  sbl_host_model #(.CPB(CPB)) sbl_host_model_inst (
    .i_clock(clk), .i_tx_line(tx), .o_rx_line(rx_line), .o_rx_byte(rx_byte),
    .o_rx_stop(rx_stop), .o_rx_count(rx_cnt)
  );

  always @(posedge clk)
  begin
    if (ram_we === 1'b1)
    begin
      wa.push_back(ram_addr);
      wd.push_back(ram_wdata);
    end
    if (jump === 1'b1)
    begin
      jump_seen <= 1'b1;
      jaddr <= jump_addr;
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // a hung handshake would otherwise run forever
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      err_total++;
      $display("timeout after %0d cycles", cycles);
      end_of_test;
    end
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic ev(input int w);
    case (w)
      0: return erase_all;
      1: return !erase_all;
      2: return jump_seen;
      default: return rx_cnt == 8'h01;
    endcase
  endfunction

  task automatic wait_ev(input string what, input int w, input int lim);
    int n;
    n = 0;
    while (ev(w) !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    check_bit(what, 1'b1, ev(w));
  endtask

  initial
  begin
    logic [31:0] d;
    cyc(10);
    srst <= 1'b0;
    cyc(3);
    reg_rd(REG_STATUS, d);
    check_val("status after reset", 32'h0, d);
    init_n <= 1'b1;
    cyc(10);
    check_bit("boot latch", 1'b1, boot);
    check_bit("mode3 latch", 1'b1, mode3);
    check_bit("loader ram lock", 1'b1, lock);
    check_bit("user prog in boot", 1'b0, upm);
    standby <= 1'b1;
    cyc(6);
    check_bit("standby under hv", 1'b0, grant);
    standby <= 1'b0;
    hv_md <= 1'b0;
    cyc(150);
    sbl_host_model_inst.send_byte(8'h00, CPB);
    wait_ev("align byte", 3, 12 * CPB);
    check_val("align value", 32'h0, rx_byte);
    check_bit("align stop bit", 1'b1, rx_stop);
    check_bit("boot kept", 1'b1, boot);
    check_val("divisor port", CPB - 1, div);
    reg_rd(REG_BAUD, d);
    check_val("divisor reg", CPB - 1, d);
    reg_rd(REG_STATUS, d);
    check_bit("aligned flag", 1'b1, d[ST_ALIGN_POS]);
    // a wrong reply must not move the loader on
    sbl_host_model_inst.send_byte(8'hff, CPB);
    check_bit("ack ignored", 1'b0, erase_all);
    sbl_host_model_inst.send_byte(8'h55, CPB);
    wait_ev("erase start", 0, 200);
    cyc(3);
    check_bit("irq block", 1'b1, irq_blk);
    check_bit("flash read block", 1'b1, frb);
    erase_done <= 1'b1;
    cyc(1);
    erase_done <= 1'b0;
    blank <= 1'b1;
    wait_ev("erase end", 1, 20);
    foreach (seq[i]) sbl_host_model_inst.send_byte(seq[i], CPB);
    wait_ev("jump", 2, 4 * CPB);
    check_val("jump addr", 32'hfbe0, jaddr);
    check_val("ram writes", 32'h2, wa.size());
    for (int i = 0; i < 2; i++)
    begin
      check_val("ram addr", 32'hfbe0 + i, wa[i]);
      check_val("ram data", seq[i + 2], wd[i]);
    end
    cyc(3);
    check_bit("rx off", 1'b0, rx_on);
    check_bit("tx off", 1'b0, tx_on);
    check_bit("tx dir", 1'b1, dir);
    check_bit("tx out", 1'b1, outb);
    check_bit("tx pin", 1'b1, tx);
    check_val("divisor kept", CPB - 1, div);
    check_bit("loader ram free", 1'b0, lock);
    reg_wr(REG_BAUD, 32'h0000abcd);
    reg_rd(REG_BAUD, d);
    check_val("divisor rw", 32'h0000abcd, d);
    reg_wr(REG_CTRL, 32'h3);
    reg_rd(REG_CTRL, d);
    check_val("ctrl rw", 32'h3, d);
    reg_wr(REG_CTRL, 32'h0);
    reg_wr(2'h3, 32'hffffffff);
    reg_rd(2'h3, d);
    check_val("unmapped read", 32'h0, d);
    wdt <= 1'b1; // watchdog reset under 12 V; the boot latch must survive it
    cyc(1);
    wdt <= 1'b0;
    cyc(5);
    check_bit("boot after watchdog", 1'b1, boot);
    check_bit("loader restarted", 1'b1, lock);
    init_n <= 1'b0;
    cyc(12);
    flash_hv_pin <= 1'b0;
    cyc(2);
    init_n <= 1'b1;
    cyc(10);
    check_bit("boot released", 1'b0, boot);
    access <= 1'b1;
    flash_hv_pin <= 1'b1;
    cyc(6);
    check_bit("upm during access", 1'b0, upm);
    access <= 1'b0;
    cyc(6);
    check_bit("upm entered", 1'b1, upm);
    standby <= 1'b1;
    busy <= 1'b1;
    cyc(6);
    check_bit("standby refused", 1'b0, grant);
    check_bit("irq block busy", 1'b1, irq_blk);
    busy <= 1'b0;
    flash_hv_pin <= 1'b0;
    cyc(6);
    check_bit("upm left", 1'b0, upm);
    check_bit("standby granted", 1'b1, grant);
    standby <= 1'b0;
    // restart boot and offer an unsupported rate
    init_n <= 1'b0;
    hv_md <= 1'b1;
    flash_hv_pin <= 1'b1;
    cyc(12);
    init_n <= 1'b1;
    cyc(150);
    sbl_host_model_inst.send_byte(8'h00, CPB * 7 / 10);
    cyc(3 * CPB);
    reg_rd(REG_STATUS, d);
    check_bit("rate refused", 1'b1, d[ST_FAIL_POS]);
    check_val("no align byte", 32'h1, rx_cnt);
    // second legal rate: divisor follows the slower host
    init_n <= 1'b0;
    cyc(12);
    init_n <= 1'b1;
    cyc(150);
    sbl_host_model_inst.send_byte(8'h00, 2 * CPB);
    cyc(20);
    check_val("mid rate divisor", 2 * CPB - 1, div);
    reg_rd(REG_STATUS, d);
    check_bit("mid rate aligned", 1'b1, d[ST_ALIGN_POS]);
    end_of_test;
  end
endmodule
